// ===== hw/alert_flags_pkg.sv
package alert_flags_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] addr_alert_mask_enable    = 8'h0F;
  localparam logic [7:0] addr_power_valid_upper    = 8'h10;
  localparam logic [7:0] addr_config               = 8'h00;
  // ---------------------------------------------------------------
  // alert mask and enable field positions
  // ---------------------------------------------------------------
  localparam int bit_reserved_top      = 15;
  localparam int bit_sum_sel_hi        = 14;
  localparam int bit_sum_sel_lo        = 12;
  localparam int bit_warn_latch        = 11;
  localparam int bit_crit_latch        = 10;
  localparam int bit_crit_flag_hi      = 9;
  localparam int bit_crit_flag_lo      = 7;
  localparam int bit_sum_flag          = 6;
  localparam int bit_warn_flag_hi      = 5;
  localparam int bit_warn_flag_lo      = 3;
  localparam int bit_power_good_flag   = 2;
  localparam int bit_timing_flag       = 1;
  localparam int bit_conv_done_flag    = 0;
  // ---------------------------------------------------------------
  // reset values and upper limit write mask
  // ---------------------------------------------------------------
  localparam logic [15:0] rst_alert_mask_enable = 16'h0002;
  localparam logic [15:0] rst_power_valid_upper = 16'h2710;
  localparam logic [15:0] pv_upper_write_mask   = 16'hFFF8;
  // ---------------------------------------------------------------
  // operating mode field of the configuration register
  // ---------------------------------------------------------------
  localparam int bit_mode_hi           = 2;
  localparam int bit_mode_lo           = 0;
  localparam int bit_mode_bus          = 1;
  localparam int bit_mode_shunt        = 0;
endpackage

// ===== hw/alert_compare.sv
`timescale 1ns/1ps
module alert_compare #(
  parameter int width = 16
) (
  input  wire logic signed [width-1:0] value,
  input  wire logic signed [width-1:0] limit,
  output logic                         above
);
  if (width < 2)
  begin : g_bad_width
    $error("alert_compare width too small");
  end
  assign above = value > limit;
endmodule

// ===== hw/alert_flag_cell.sv
`timescale 1ns/1ps
module alert_flag_cell (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic set_event,
  input  wire logic clear_req,
  output logic      flag
);
  // set wins over clear in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      flag <= 1'b0;
    else if (set_event)
      flag <= 1'b1;
    else if (clear_req)
      flag <= 1'b0;
  end
endmodule

// ===== hw/alert_mask_flags_power_valid.sv
// What this block does
// [R1] reading mask register clears event flags
// [R2] writing mask register leaves flags unchanged
// [R3] host reads register before changing settings
// [R4] three bits select channels into sum
// [R5] sum selection never touches channel results
// [R6] warning latch bit selects latched output
// [R7] critical latch bit selects latched output
// [R8] critical flags set with critical output
// [R9] sum flag set, critical output asserts
// [R10] warning flags set with warning output
// [R11] power good flag mirrors output pin
// [R12] power good flag not cleared by read
// [R13] timing flag mirrors timing output pin
// [R14] timing flag held, reset sets it high
// [R15] mask register reads 0002h after reset
// [R16] done flag set after cycle completes
// [R17] done flag cleared by read, config write with mode bits 1:0 nonzero
// [R18] all bus channels above limit: good
// [R19] monitoring only with bus mode enabled
// [R20] upper limit resets to 2710h, 8mV step
// [R21] upper limit sign, data, reserved zero
// [R22] any channel below lower limit: not good
// [R23] sum compared after each completed cycle with any channel selected
// [R24] latched output held until mask read
// [R25] reserved top bit stores written value
`timescale 1ns/1ps
module alert_mask_flags_power_valid #(
  parameter int channels = 3,
  parameter int data_w   = 16
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic [7:0]                 reg_addr,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  input  wire logic [data_w-1:0]          reg_wdata,
  output logic      [data_w-1:0]          reg_rdata,
  input  wire logic [2:0]                 operating_mode_bits,
  input  wire logic [channels-1:0]        shunt_conv_valid,
  input  wire logic [channels*data_w-1:0] shunt_value,
  input  wire logic [channels*data_w-1:0] crit_limit,
  input  wire logic [channels-1:0]        avg_valid,
  input  wire logic [channels*data_w-1:0] avg_value,
  input  wire logic [channels*data_w-1:0] warn_limit,
  input  wire logic                       cycle_done,
  input  wire logic [data_w-1:0]          sum_value,
  input  wire logic [data_w-1:0]          sum_limit,
  input  wire logic [channels*data_w-1:0] bus_value,
  input  wire logic [data_w-1:0]          pv_lower_limit,
  input  wire logic                       timing_event,
  output logic      [channels-1:0]        sum_channel_select,
  output logic                            critical_out,
  output logic                            warning_out,
  output logic                            power_good_output,
  output logic                            timing_control_output
);
  if (channels != 3 || data_w != 16)
  begin : g_bad_params
    $error("block serves three channels of sixteen bits");
  end

  // ---------------------------------------------------------------
  // register access decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction
  function automatic logic [channels-1:0] chan_order(input logic [channels-1:0] v);
    chan_order = {<<{v}};
  endfunction

  logic mask_rd;
  logic mask_wr;
  logic pvu_wr;
  logic cfg_wr;
  logic cfg_keeps_done;
  assign mask_rd = reg_rd && hit(reg_addr, alert_flags_pkg::addr_alert_mask_enable);
  assign mask_wr = reg_wr && hit(reg_addr, alert_flags_pkg::addr_alert_mask_enable);
  assign pvu_wr  = reg_wr && hit(reg_addr, alert_flags_pkg::addr_power_valid_upper);
  assign cfg_wr  = reg_wr && hit(reg_addr, alert_flags_pkg::addr_config);
  // power-down and disable modes have no measurement bits set
  assign cfg_keeps_done = (reg_wdata[alert_flags_pkg::bit_mode_bus:
                                     alert_flags_pkg::bit_mode_shunt] == 2'h0);

  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  logic                reserved_top_reg;
  logic                warn_latch_reg;
  logic                crit_latch_reg;
  logic [data_w-1:0]   pv_upper_reg;

  // [R2] [R4] [R25] control-only write
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      reserved_top_reg   <= alert_flags_pkg::rst_alert_mask_enable[15];
      sum_channel_select <= alert_flags_pkg::rst_alert_mask_enable[14:12];
      warn_latch_reg     <= alert_flags_pkg::rst_alert_mask_enable[11];
      crit_latch_reg     <= alert_flags_pkg::rst_alert_mask_enable[10];
    end
    else if (mask_wr)
    begin
      reserved_top_reg   <= reg_wdata[alert_flags_pkg::bit_reserved_top];
      sum_channel_select <= chan_order(reg_wdata[alert_flags_pkg::bit_sum_sel_hi:
                                                 alert_flags_pkg::bit_sum_sel_lo]);
      warn_latch_reg     <= reg_wdata[alert_flags_pkg::bit_warn_latch];
      crit_latch_reg     <= reg_wdata[alert_flags_pkg::bit_crit_latch];
    end
  end

  // [R20] [R21] upper limit, reserved low bits forced zero
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      pv_upper_reg <= alert_flags_pkg::rst_power_valid_upper;
    else if (pvu_wr)
      pv_upper_reg <= reg_wdata & alert_flags_pkg::pv_upper_write_mask;
  end

  // ---------------------------------------------------------------
  // per channel compares and flags
  // ---------------------------------------------------------------
  logic [channels-1:0] crit_above;
  logic [channels-1:0] warn_above;
  logic [channels-1:0] bus_above_upper;
  logic [channels-1:0] bus_below_lower;
  logic [channels-1:0] crit_hit;
  logic [channels-1:0] warn_hit;
  logic [channels-1:0] critical_channel_flags;
  logic [channels-1:0] warning_channel_flags;

  // [R5] selection never gates per-channel compares
  for (genvar ch = 0; ch < channels; ch++)
  begin : g_ch
    alert_compare #(.width(data_w)) u_crit (
      .value (shunt_value[ch*data_w +: data_w]),
      .limit (crit_limit[ch*data_w +: data_w]),
      .above (crit_above[ch])
    );
    alert_compare #(.width(data_w)) u_warn (
      .value (avg_value[ch*data_w +: data_w]),
      .limit (warn_limit[ch*data_w +: data_w]),
      .above (warn_above[ch])
    );
    alert_compare #(.width(data_w)) u_pvu (
      .value (bus_value[ch*data_w +: data_w]),
      .limit (pv_upper_reg),
      .above (bus_above_upper[ch])
    );
    alert_compare #(.width(data_w)) u_pvl (
      .value (pv_lower_limit),
      .limit (bus_value[ch*data_w +: data_w]),
      .above (bus_below_lower[ch])
    );
    // [R8] critical conversion event
    assign crit_hit[ch] = shunt_conv_valid[ch] && crit_above[ch];
    // [R10] averaged warning event
    assign warn_hit[ch] = avg_valid[ch] && warn_above[ch];
    // [R1] flag cleared on mask read
    alert_flag_cell u_cf (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .set_event (crit_hit[ch]),
      .clear_req (mask_rd),
      .flag      (critical_channel_flags[ch])
    );
    alert_flag_cell u_wf (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .set_event (warn_hit[ch]),
      .clear_req (mask_rd),
      .flag      (warning_channel_flags[ch])
    );
  end

  // ---------------------------------------------------------------
  // summation and conversion done
  // ---------------------------------------------------------------
  logic sum_above;
  logic sum_hit;
  logic summation_flag;
  logic conversion_done_flag;

  alert_compare #(.width(data_w)) u_sum (
    .value (sum_value),
    .limit (sum_limit),
    .above (sum_above)
  );
  // [R23] [R9] sum checked on each completed cycle with any channel selected
  assign sum_hit = cycle_done && (|sum_channel_select) && sum_above;
  alert_flag_cell u_sf (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .set_event (sum_hit),
    .clear_req (mask_rd),
    .flag      (summation_flag)
  );
  // [R16] [R17] done flag set wins over clear
  alert_flag_cell u_done (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .set_event (cycle_done),
    .clear_req (mask_rd || (cfg_wr && !cfg_keeps_done)),
    .flag      (conversion_done_flag)
  );

  // ---------------------------------------------------------------
  // alert outputs
  // ---------------------------------------------------------------
  logic crit_now;
  logic warn_now;
  logic crit_hold_reg;
  logic warn_hold_reg;
  assign crit_now = (|crit_hit) || sum_hit;
  assign warn_now = |warn_hit;

  // [R24] [R6] [R7] hold or follow
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      crit_hold_reg <= 1'b0;
      warn_hold_reg <= 1'b0;
      critical_out  <= 1'b0;
      warning_out   <= 1'b0;
    end
    else
    begin
      crit_hold_reg <= crit_now || (crit_hold_reg && !mask_rd);
      warn_hold_reg <= warn_now || (warn_hold_reg && !mask_rd);
      critical_out  <= crit_latch_reg ? (crit_now || (crit_hold_reg && !mask_rd)) : crit_now;
      warning_out   <= warn_latch_reg ? (warn_now || (warn_hold_reg && !mask_rd)) : warn_now;
    end
  end

  // ---------------------------------------------------------------
  // power good and timing control
  // ---------------------------------------------------------------
  logic bus_mode_on;
  assign bus_mode_on = operating_mode_bits[alert_flags_pkg::bit_mode_bus];

  // [R18] [R19] [R22] set above upper, drop below lower
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      power_good_output <= 1'b0;
    else if (!bus_mode_on)
      power_good_output <= 1'b0;
    else if (|bus_below_lower)
      power_good_output <= 1'b0;
    else if (&bus_above_upper)
      power_good_output <= 1'b1;
  end

  // [R14] [R15] timing flag high from reset, sticky
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      timing_control_output <= alert_flags_pkg::rst_alert_mask_enable[1];
    else if (timing_event)
      timing_control_output <= 1'b1;
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [data_w-1:0] mask_view;
  // [R11] [R13] [R12] flags mirror pins, no read clear
  assign mask_view = {reserved_top_reg, chan_order(sum_channel_select), warn_latch_reg,
                      crit_latch_reg, chan_order(critical_channel_flags), summation_flag,
                      chan_order(warning_channel_flags),
                      power_good_output, timing_control_output, conversion_done_flag};

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else if (mask_rd)
      reg_rdata <= mask_view;
    else if (reg_rd && hit(reg_addr, alert_flags_pkg::addr_power_valid_upper))
      reg_rdata <= pv_upper_reg;
    else if (reg_rd)
      reg_rdata <= 16'h0000;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_read_clears;
    @(posedge sys_clk) disable iff (rst)
      (mask_rd && !crit_now && !warn_now && !cycle_done) |=>
        (critical_channel_flags == 3'h0) && !summation_flag && !conversion_done_flag;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flags not cleared"); // [R1]
  property p_write_keeps_flags;
    @(posedge sys_clk) disable iff (rst)
      (mask_wr && !reg_rd && |warning_channel_flags) |=> |warning_channel_flags;
  endproperty
  a_write_keeps_flags: assert property (p_write_keeps_flags) else $error("write lost flag"); // [R2]
  property p_crit_sets;
    @(posedge sys_clk) disable iff (rst) (|crit_hit) |=> critical_out && (|critical_channel_flags);
  endproperty
  a_crit_sets: assert property (p_crit_sets) else $error("critical not raised"); // [R8]
  property p_sum_sets;
    @(posedge sys_clk) disable iff (rst) sum_hit |=> summation_flag && critical_out;
  endproperty
  a_sum_sets: assert property (p_sum_sets) else $error("sum alert missing"); // [R9]
  property p_warn_sets;
    @(posedge sys_clk) disable iff (rst) (|warn_hit) |=> warning_out && (|warning_channel_flags);
  endproperty
  a_warn_sets: assert property (p_warn_sets) else $error("warning not raised"); // [R10]
  property p_timing_sticky;
    @(posedge sys_clk) disable iff (rst) timing_control_output |=> timing_control_output;
  endproperty
  a_timing_sticky: assert property (p_timing_sticky) else $error("timing flag dropped"); // [R14]
  property p_pg_needs_bus;
    @(posedge sys_clk) disable iff (rst) !bus_mode_on |=> !power_good_output;
  endproperty
  a_pg_needs_bus: assert property (p_pg_needs_bus) else $error("pg without bus mode"); // [R19]
  property p_pg_rise;
    @(posedge sys_clk) disable iff (rst) $rose(power_good_output) |-> $past(&bus_above_upper);
  endproperty
  a_pg_rise: assert property (p_pg_rise) else $error("pg rose without cause"); // [R18]
  property p_transparent;
    @(posedge sys_clk) disable iff (rst) (!crit_latch_reg && !crit_now) |=> !critical_out;
  endproperty
  a_transparent: assert property (p_transparent) else $error("critical held"); // [R7]
  property p_pv_reserved;
    @(posedge sys_clk) disable iff (rst)
      pvu_wr |=> (pv_upper_reg[2:0] == 3'h0) && (pv_upper_reg[15:3] == $past(reg_wdata[15:3]));
  endproperty
  a_pv_reserved: assert property (p_pv_reserved) else $error("upper limit bad"); // [R21]
endmodule

// ===== bench/sense_model.sv
`timescale 1ns/1ps
module sense_model (
  input  wire logic        sys_clk,
  output logic [2:0]       shunt_conv_valid,
  output logic [47:0]      shunt_value,
  output logic [47:0]      crit_limit,
  output logic [2:0]       avg_valid,
  output logic [47:0]      avg_value,
  output logic [47:0]      warn_limit,
  output logic             cycle_done,
  output logic [15:0]      sum_value,
  output logic [15:0]      sum_limit,
  output logic [47:0]      bus_value,
  output logic [15:0]      pv_lower_limit,
  output logic             timing_event
);
  // ---------------------------------------------------------------
  // measurement side levels
  // ---------------------------------------------------------------
  initial
  begin
    shunt_conv_valid = 3'h0;
    avg_valid        = 3'h0;
    cycle_done       = 1'b0;
    timing_event     = 1'b0;
    shunt_value      = 48'h0;
    avg_value        = 48'h0;
    sum_value        = 16'h0000;
    bus_value        = 48'h0;
    crit_limit       = {3{16'h0100}};
    warn_limit       = {3{16'h0100}};
    sum_limit        = 16'h0400;
    pv_lower_limit   = 16'h2328;
  end
  // ---------------------------------------------------------------
  // one conversion result per call, one cycle pulse; set tasks hold levels
  // ---------------------------------------------------------------
  // single conversion per channel
  task automatic crit_hit(input int ch, input logic over);
    @(negedge sys_clk);
    shunt_value[ch*16 +: 16] = over ? 16'h0200 : 16'h0080;
    shunt_conv_valid[ch]     = 1'b1;
    @(negedge sys_clk);
    shunt_conv_valid = 3'h0;
  endtask
  task automatic warn_hit(input int ch);
    @(negedge sys_clk);
    avg_value[ch*16 +: 16] = 16'h0200;
    avg_valid[ch]          = 1'b1;
    @(negedge sys_clk);
    avg_valid = 3'h0;
  endtask
  // end of a full conversion cycle
  task automatic cycle_end(input logic [15:0] sum);
    @(negedge sys_clk);
    sum_value  = sum;
    cycle_done = 1'b1;
    @(negedge sys_clk);
    cycle_done = 1'b0;
  endtask
  task automatic set_bus(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    @(negedge sys_clk);
    bus_value = {c, b, a};
  endtask
  task automatic timing_hit();
    @(negedge sys_clk);
    timing_event = 1'b1;
    @(negedge sys_clk);
    timing_event = 1'b0;
  endtask
  task automatic set_limits(input logic [15:0] crit, input logic [15:0] sum,
                            input logic [15:0] lower);
    @(negedge sys_clk);
    crit_limit     = {3{crit}};
    warn_limit     = {3{crit}};
    sum_limit      = sum;
    pv_lower_limit = lower;
  endtask
endmodule

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk;
  logic        rst;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [2:0]  operating_mode_bits;
  logic [2:0]  shunt_conv_valid;
  logic [47:0] shunt_value;
  logic [47:0] crit_limit;
  logic [2:0]  avg_valid;
  logic [47:0] avg_value;
  logic [47:0] warn_limit;
  logic        cycle_done;
  logic [15:0] sum_value;
  logic [15:0] sum_limit;
  logic [47:0] bus_value;
  logic [15:0] pv_lower_limit;
  logic        timing_event;
  logic [2:0]  sum_channel_select;
  logic        critical_out;
  logic        warning_out;
  logic        power_good_output;
  logic        timing_control_output;
  int          miscompares;
  int          checks;
  int          ch;

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  alert_mask_flags_power_valid i_dut (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .operating_mode_bits(operating_mode_bits),
    .shunt_conv_valid(shunt_conv_valid), .shunt_value(shunt_value), .crit_limit(crit_limit),
    .avg_valid(avg_valid), .avg_value(avg_value), .warn_limit(warn_limit),
    .cycle_done(cycle_done), .sum_value(sum_value), .sum_limit(sum_limit),
    .bus_value(bus_value), .pv_lower_limit(pv_lower_limit), .timing_event(timing_event),
    .sum_channel_select(sum_channel_select), .critical_out(critical_out),
    .warning_out(warning_out), .power_good_output(power_good_output),
    .timing_control_output(timing_control_output)
  );

  sense_model i_sense (
    .sys_clk(sys_clk), .shunt_conv_valid(shunt_conv_valid), .shunt_value(shunt_value),
    .crit_limit(crit_limit), .avg_valid(avg_valid), .avg_value(avg_value),
    .warn_limit(warn_limit), .cycle_done(cycle_done), .sum_value(sum_value),
    .sum_limit(sum_limit), .bus_value(bus_value), .pv_lower_limit(pv_lower_limit),
    .timing_event(timing_event)
  );

  // ---------------------------------------------------------------
  // access and compare tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    check("reg_rdata", reg_rdata, exp);
  endtask

  task automatic wait_pv(input logic want);
    int n;
    n = 0;
    while (power_good_output !== want && n < 20)
    begin
      @(negedge sys_clk);
      n++;
    end
    check("power_good_output", {15'h0, power_good_output}, {15'h0, want});
    if (n >= 20)
    begin
      stop_test();
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    miscompares = 0;
    checks = 0;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
    operating_mode_bits = 3'h7;
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    check("tc_out", {15'h0, timing_control_output}, 16'h0001);
    rd(8'h0F, 16'h0002);
    rd(8'h10, 16'h2710);
    rd(8'h05, 16'h0000);
    wr(8'h10, 16'hFFFF);
    rd(8'h10, 16'hFFF8);
    wr(8'h10, 16'h2710);
    wr(8'h0F, 16'hFFFF);
    check("sum_sel", {13'h0, sum_channel_select}, 16'h0007);
    rd(8'h0F, 16'hFC02);
    wr(8'h0F, 16'h0000);
    for (ch = 0; ch < 3; ch++)
    begin
      i_sense.crit_hit(ch, 1'b1);
      check("crit_out", {15'h0, critical_out}, 16'h0001);
      @(negedge sys_clk);
      check("crit_out", {15'h0, critical_out}, 16'h0000);
      i_sense.warn_hit(ch);
      check("warn_out", {15'h0, warning_out}, 16'h0001);
      @(negedge sys_clk);
      check("warn_out", {15'h0, warning_out}, 16'h0000);
      rd(8'h0F, 16'h0002 | (16'h0200 >> ch) | (16'h0020 >> ch));
      rd(8'h0F, 16'h0002);
    end
    i_sense.crit_hit(0, 1'b0);
    check("crit_out", {15'h0, critical_out}, 16'h0000);
    rd(8'h0F, 16'h0002);
    wr(8'h0F, 16'h0C00);
    i_sense.crit_hit(1, 1'b1);
    i_sense.warn_hit(2);
    repeat (5) @(negedge sys_clk);
    wr(8'h0F, 16'h0C00);
    check("crit_out", {15'h0, critical_out}, 16'h0001);
    check("warn_out", {15'h0, warning_out}, 16'h0001);
    rd(8'h0F, 16'h0D0A);
    @(negedge sys_clk);
    check("crit_out", {15'h0, critical_out}, 16'h0000);
    check("warn_out", {15'h0, warning_out}, 16'h0000);
    wr(8'h0F, 16'h7000);
    i_sense.cycle_end(16'h0500);
    check("crit_out", {15'h0, critical_out}, 16'h0001);
    rd(8'h0F, 16'h7043);
    i_sense.cycle_end(16'h0300);
    rd(8'h0F, 16'h7003);
    i_sense.set_limits(16'h0300, 16'h0600, 16'h2000);
    i_sense.crit_hit(2, 1'b1);
    check("crit_out", {15'h0, critical_out}, 16'h0000);
    i_sense.warn_hit(0);
    i_sense.cycle_end(16'h0500);
    rd(8'h0F, 16'h7003);
    i_sense.set_limits(16'h0100, 16'h0400, 16'h2328);
    wr(8'h0F, 16'h0000);
    i_sense.cycle_end(16'h0500);
    rd(8'h0F, 16'h0003);
    i_sense.cycle_end(16'h0000);
    wr(8'h00, 16'h0007);
    rd(8'h0F, 16'h0002);
    i_sense.cycle_end(16'h0000);
    wr(8'h00, 16'h0000);
    rd(8'h0F, 16'h0003);
    i_sense.set_bus(16'h2800, 16'h2800, 16'h2400);
    repeat (8) @(negedge sys_clk);
    check("pv_out", {15'h0, power_good_output}, 16'h0000);
    i_sense.set_bus(16'h2800, 16'h2800, 16'h2800);
    wait_pv(1'b1);
    rd(8'h0F, 16'h0006);
    rd(8'h0F, 16'h0006);
    i_sense.set_bus(16'h2800, 16'h2800, 16'h2400);
    repeat (8) @(negedge sys_clk);
    check("pv_out", {15'h0, power_good_output}, 16'h0001);
    i_sense.set_bus(16'h2800, 16'h2000, 16'h2800);
    wait_pv(1'b0);
    rd(8'h0F, 16'h0002);
    operating_mode_bits = 3'h1;
    i_sense.set_bus(16'h2800, 16'h2800, 16'h2800);
    repeat (8) @(negedge sys_clk);
    check("pv_out", {15'h0, power_good_output}, 16'h0000);
    i_sense.timing_hit();
    wr(8'h0F, 16'h0000);
    rd(8'h0F, 16'h0002);
    check("tc_out", {15'h0, timing_control_output}, 16'h0001);
    wr(8'h10, 16'h1238);
    wr(8'h0F, 16'hFC00);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    rd(8'h0F, 16'h0002);
    rd(8'h10, 16'h2710);
    stop_test();
  end
endmodule
